//--- hw/spct_pkg.sv
// Package for the sync PWM / clamp / period-measure timer link.
// Assumes one 100 MHz system clock; registers reached over a plain strobe port.
package spct_pkg;
    // Register word offsets
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_CMPA1 = 4'h1;
    localparam logic [3:0] ADR_CMPB1 = 4'h2;
    localparam logic [3:0] ADR_CMPC1 = 4'h3;
    localparam logic [3:0] ADR_CMPA2 = 4'h4;
    localparam logic [3:0] ADR_CMPB2 = 4'h5;
    localparam logic [3:0] ADR_OSEL = 4'h6;
    localparam logic [3:0] ADR_CAP1 = 4'h7;
    localparam logic [3:0] ADR_CAPB = 4'h8;
    localparam logic [3:0] ADR_STAT = 4'h9;
    localparam logic [3:0] ADR_CNT = 4'hA;
    // Control register fields
    localparam int CTRL_CLKSEL_LSB = 0;
    localparam int CTRL_CLRSEL_LSB = 3;
    localparam int CTRL_EDGEB_BIT = 5;
    localparam int CTRL_FRCLK_LSB = 6;
    // Codes
    localparam logic [2:0] CKS_SYS = 3'h1;
    localparam logic [2:0] CKS_SYS_DIV2 = 3'h2;
    localparam logic [2:0] CKS_EXT_RISE = 3'h5;
    localparam logic [1:0] CCLR_EXT = 2'h3;
    localparam logic [1:0] FRCKS_DIV8 = 2'h1;
    localparam logic [3:0] OS_TOGGLE_A = 4'h3;
    localparam logic [3:0] OS_SETB_CLRA = 4'h9;
    localparam int FR_DIV8 = 8;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h59;
    localparam logic [7:0] CMP_RST = 8'hFF;
    localparam logic [3:0] OSEL_RST = 4'h0;
endpackage

//--- hw/spct_timer_link.sv
// Sync timer link: PWM decoder, three clamp pulses, divided-waveform period capture.
// Assumes sync pins are asynchronous and a host drives the plain register strobe port.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module spct_timer_link (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_hsync,
    input wire logic i_vsync,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_decoded_pwm_out,
    output logic o_clamp_pulse_one,
    output logic o_clamp_pulse_two,
    output logic o_clamp_pulse_three,
    output logic o_timer_output_pin,
    output logic o_capture_b_event
);
    import spct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic rst_s1_r, rst_n;
    logic hs_s1_r, hs_s2_r, hs_d_r, vs_s1_r, vs_s2_r, vs_d_r;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // Two-flop synchronisers plus one delay for edge detection
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            hs_s1_r <= 1'b0;
            hs_s2_r <= 1'b0;
            hs_d_r <= 1'b0;
            vs_s1_r <= 1'b0;
            vs_s2_r <= 1'b0;
            vs_d_r <= 1'b0;
        end else if (i_ce) begin
            hs_s1_r <= i_hsync;
            hs_s2_r <= hs_s1_r;
            hs_d_r <= hs_s2_r;
            vs_s1_r <= i_vsync;
            vs_s2_r <= vs_s1_r;
            vs_d_r <= vs_s2_r;
        end
    end

    logic hs_rise, hs_fall, vs_fall;
    assign hs_rise = hs_s2_r & ~hs_d_r;
    assign hs_fall = ~hs_s2_r & hs_d_r;
    assign vs_fall = ~vs_s2_r & vs_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] ctrl_r, cmpa1_r, cmpb1_r, cmpc1_r, cmpa2_r, cmpb2_r;
    logic [3:0] osel_r;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            cmpa1_r <= CMP_RST;
            cmpb1_r <= CMP_RST;
            cmpc1_r <= CMP_RST;
            cmpa2_r <= CMP_RST;
            cmpb2_r <= CMP_RST;
            osel_r <= OSEL_RST;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                ADR_CTRL: ctrl_r <= i_wdata;
                ADR_CMPA1: cmpa1_r <= i_wdata;
                ADR_CMPB1: cmpb1_r <= i_wdata;
                ADR_CMPC1: cmpc1_r <= i_wdata;
                ADR_CMPA2: cmpa2_r <= i_wdata;
                ADR_CMPB2: cmpb2_r <= i_wdata;
                ADR_OSEL: osel_r <= i_wdata[3:0];
                default: ;
            endcase
        end
    end

    logic [2:0] cks1;
    logic [1:0] cclr1, frcks;
    logic edgeb;
    assign cks1 = ctrl_r[CTRL_CLKSEL_LSB +: 3];
    assign cclr1 = ctrl_r[CTRL_CLRSEL_LSB +: 2];
    assign edgeb = ctrl_r[CTRL_EDGEB_BIT];
    assign frcks = ctrl_r[CTRL_FRCLK_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // First timer: count system clocks, clear on sync rise
    logic [7:0] cnt1_r, cap1_r;
    logic div2_r, inc1, clr1, mta1, mtb1;
    assign clr1 = (cclr1 == CCLR_EXT) && hs_rise;
    assign inc1 = (cks1 == CKS_SYS) || ((cks1 == CKS_SYS_DIV2) && div2_r);
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt1_r <= 8'h00;
            div2_r <= 1'b0;
        end else if (i_ce) begin
            div2_r <= ~div2_r;
            if (clr1) begin
                cnt1_r <= 8'h00;
            end else if (inc1) begin
                cnt1_r <= cnt1_r + 8'h01;
            end
        end
    end

    // Match events: one clock pulse on the count step that reaches the value
    logic [7:0] cnt1_d_r;
    logic step1_r;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt1_d_r <= 8'h00;
            step1_r <= 1'b0;
        end else if (i_ce) begin
            cnt1_d_r <= cnt1_r;
            step1_r <= inc1 | clr1;
        end
    end
    assign mta1 = step1_r && (cnt1_r == cmpa1_r) && (cnt1_d_r != cnt1_r);
    assign mtb1 = step1_r && (cnt1_r == cmpb1_r) && (cnt1_d_r != cnt1_r);

    // Match A pipeline: the clamp fall lags match A by three clocks, so clamp one
    // stays high for compare A plus three clocks; a new sync rise flushes it
    logic c1_p1_r, c1_stop_r;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            c1_p1_r <= 1'b0;
            c1_stop_r <= 1'b0;
        end else if (i_ce) begin
            c1_p1_r <= mta1 & ~clr1;
            c1_stop_r <= c1_p1_r & ~clr1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM decoder latch, clocked by match B
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_decoded_pwm_out <= 1'b0;
        end else if (i_ce && mtb1) begin
            o_decoded_pwm_out <= hs_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clamp one and two
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_clamp_pulse_one <= 1'b0;
            o_clamp_pulse_two <= 1'b0;
        end else if (i_ce) begin
            if (hs_rise) begin
                o_clamp_pulse_one <= 1'b1;
            end else if (c1_stop_r) begin
                o_clamp_pulse_one <= 1'b0;
            end
            if (c1_stop_r) begin
                o_clamp_pulse_two <= 1'b0;
            end else if (hs_fall && o_clamp_pulse_one) begin
                o_clamp_pulse_two <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fall capture and clamp three
    logic [7:0] c3_end_r;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap1_r <= 8'h00;
            c3_end_r <= 8'h00;
            o_clamp_pulse_three <= 1'b0;
        end else if (i_ce) begin
            if (hs_fall) begin
                cap1_r <= cnt1_r;
                c3_end_r <= 8'(cnt1_r + cmpc1_r);
                o_clamp_pulse_three <= 1'b1;
            end else if (hs_rise) begin
                o_clamp_pulse_three <= 1'b0;
            end else if (o_clamp_pulse_three && step1_r && cnt1_r == c3_end_r) begin
                o_clamp_pulse_three <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second timer: counts sync rises, clears on vertical fall
    logic [7:0] cnt2_r;
    logic inc2, mta2, mtb2;
    // The second timer steps on a synchronised sync rise unless a vertical fall clears it in the same clock
    assign inc2 = hs_rise;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt2_r <= 8'h00;
        end else if (i_ce) begin
            if (vs_fall) begin
                cnt2_r <= 8'h00;
            end else if (inc2) begin
                cnt2_r <= cnt2_r + 8'h01;
            end
        end
    end
    assign mta2 = inc2 && !vs_fall && (cnt2_r + 8'h01 == cmpa2_r);
    assign mtb2 = inc2 && !vs_fall && (cnt2_r + 8'h01 == cmpb2_r);

    // Timer output response by output select
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_timer_output_pin <= 1'b0;
        end else if (i_ce) begin
            case (osel_r)
                OS_TOGGLE_A: if (mta2) o_timer_output_pin <= ~o_timer_output_pin;
                OS_SETB_CLRA: begin
                    if (mta2) begin
                        o_timer_output_pin <= 1'b0;
                    end else if (mtb2) begin
                        o_timer_output_pin <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running count and capture B on divided waveform
    logic [15:0] frc_r, capb_r;
    logic [2:0] pre_r;
    logic tmo_d_r, frc_tick, capb_hit;
    assign frc_tick = (frcks == FRCKS_DIV8) ? (pre_r == 3'(FR_DIV8 - 1)) : 1'b1;
    assign capb_hit = edgeb ? (o_timer_output_pin & ~tmo_d_r) : (~o_timer_output_pin & tmo_d_r);
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            frc_r <= 16'h0000;
            pre_r <= 3'h0;
            capb_r <= 16'h0000;
            tmo_d_r <= 1'b0;
            o_capture_b_event <= 1'b0;
        end else if (i_ce) begin
            pre_r <= pre_r + 3'h1;
            tmo_d_r <= o_timer_output_pin;
            o_capture_b_event <= capb_hit;
            if (frc_tick) begin
                frc_r <= frc_r + 16'h0001;
            end
            if (capb_hit) begin
                capb_r <= frc_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    ADR_CTRL: o_rdata <= ctrl_r;
                    ADR_CMPA1: o_rdata <= cmpa1_r;
                    ADR_CMPB1: o_rdata <= cmpb1_r;
                    ADR_CMPC1: o_rdata <= cmpc1_r;
                    ADR_CMPA2: o_rdata <= cmpa2_r;
                    ADR_CMPB2: o_rdata <= cmpb2_r;
                    ADR_OSEL: o_rdata <= {4'h0, osel_r};
                    ADR_CAP1: o_rdata <= cap1_r;
                    ADR_CAPB: o_rdata <= capb_r[15:8];
                    ADR_STAT: o_rdata <= {3'h0, o_timer_output_pin, o_clamp_pulse_three,
                                          o_clamp_pulse_two, o_clamp_pulse_one, o_decoded_pwm_out};
                    ADR_CNT: o_rdata <= cnt1_r;
                    default: o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sync_clear_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && clr1) |=> (cnt1_r == 8'h00))
        else $error("first timer not cleared on sync rise");
    count_step_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && !clr1 && cks1 == CKS_SYS) |=> (cnt1_r == $past(cnt1_r) + 8'h01))
        else $error("first timer did not step");
    decode_latch_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && mtb1) |=> (o_decoded_pwm_out == $past(hs_s2_r)))
        else $error("decoded output did not take sync level");
    clamp_rise_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && hs_rise) |=> o_clamp_pulse_one)
        else $error("clamp one missed sync rise");
    clamp_fall_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && c1_stop_r && !hs_rise) |=> (!o_clamp_pulse_one && !o_clamp_pulse_two))
        else $error("clamps not ended on match A");
    clamp_two_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && hs_fall && o_clamp_pulse_one && !c1_stop_r) |=> o_clamp_pulse_two)
        else $error("clamp two missed sync fall");
    fall_capture_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && hs_fall) |=> (cap1_r == $past(cnt1_r) && o_clamp_pulse_three))
        else $error("fall capture or clamp three wrong");
    clamp3_rise_end_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && hs_rise) |=> !o_clamp_pulse_three)
        else $error("clamp three not ended by sync rise");
    vclear_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && vs_fall) |=> (cnt2_r == 8'h00))
        else $error("second timer not cleared");
    toggle_out_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && osel_r == OS_TOGGLE_A && mta2) |=> (o_timer_output_pin != $past(o_timer_output_pin)))
        else $error("timer output did not toggle");
endmodule
`default_nettype wire

//--- dv/spct_sync_src.sv
// Sync pin source standing in for the video sync inputs.
// Assumes the bench calls its tasks; pins change only just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module spct_sync_src (
    input wire logic i_mclk,
    output logic o_hsync,
    output logic o_vsync
);
    // Both pins rest low between lines and frames
    initial begin
        o_hsync = 1'b0;
        o_vsync = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One line: high for hi clocks, then low for lo clocks; callers keep the clamp
    // one width above hi where clamp two is wanted
    task automatic line(input int hi, input int lo);
        @(posedge i_mclk);
        o_hsync <= 1'b1;
        repeat (hi) @(posedge i_mclk);
        o_hsync <= 1'b0;
        repeat (lo) @(posedge i_mclk);
    endtask

    // Vertical pulse; its fall clears the line counter
    task automatic frame();
        @(posedge i_mclk);
        o_vsync <= 1'b1;
        repeat (6) @(posedge i_mclk);
        o_vsync <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Testbench for the sync timer link: decoder, clamps, divided output, captures.
// Assumes the sync source model and a 100 MHz clock; reset held 10 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import spct_pkg::*;
    logic i_mclk, i_rstn, i_ce, i_wr, i_rd, hs, vs, hs_d, c1_d, c2_d;
    logic pwm, clamp1, clamp2, clamp3, tout, capev, tout_m;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rv, cnt_m, cb1;
    int fails, cmp_count, seed, t, c1end, c2end, c1n, c2n, c3n, capn, cap_m, w, r, c1s, c2s, c3s, capb;

    spct_sync_src src (.i_mclk(i_mclk), .o_hsync(hs), .o_vsync(vs));
    spct_timer_link uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_hsync(hs), .i_vsync(vs),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_decoded_pwm_out(pwm), .o_clamp_pulse_one(clamp1), .o_clamp_pulse_two(clamp2),
        .o_clamp_pulse_three(clamp3), .o_timer_output_pin(tout), .o_capture_b_event(capev));

    // Free-running system clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Clamp fall times from the sync rise, high-cycle and capture counts
    always @(posedge i_mclk) begin
        hs_d <= hs;
        c1_d <= clamp1;
        c2_d <= clamp2;
        t <= (hs && !hs_d) ? 0 : t + 1;
        if (c1_d && !clamp1) c1end <= t + 1;
        if (c2_d && !clamp2) c2end <= t + 1;
        if (clamp1) c1n <= c1n + 1;
        if (clamp2) c2n <= c2n + 1;
        if (clamp3) c3n <= c3n + 1;
        if (capev) capn <= capn + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One line with clamp one and two checks against compare value a
    task automatic hl(input int hi, input int lo, input int a);
        c1s = c1n;
        c2s = c2n;
        c3s = c3n;
        src.line(hi, lo);
        chk(16'(c1n - c1s), 16'(a + 3));
        chk(16'(c2n != c2s), 16'(hi < a + 3));
        if (c2n != c2s) chk(16'(c2end), 16'(c1end));
    endtask

    // One line on the second timer, with the output model stepped alongside
    task automatic tstep(input logic [3:0] os, input logic [7:0] a, input logic [7:0] b, input logic er);
        logic nt;
        src.line(3, 8);
        cnt_m = cnt_m + 8'h01;
        nt = tout_m;
        if (os == OS_SETB_CLRA && cnt_m == b) nt = 1'b1;
        if (cnt_m == a) nt = (os == OS_TOGGLE_A) ? ~tout_m : 1'b0;
        if (nt != tout_m && nt == er) cap_m++;
        tout_m = nt;
        #1 chk(16'(tout), 16'(tout_m));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
        i_ce = 1'b1;
        {fails, cmp_count, t, c1end, c2end, c1n, c2n, c3n, capn, cap_m} = '0;
        seed = 32'h145f;
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        // Reset values, an unmapped index, write and read back
        rd(ADR_CTRL, rv); chk(16'(rv), 16'(CTRL_RST));
        rd(ADR_CMPA1, rv); chk(16'(rv), 16'(CMP_RST));
        rd(ADR_OSEL, rv); chk(16'(rv), 16'(OSEL_RST));
        rd(4'hB, rv); chk(16'(rv), 16'h0000);
        // Clock enable low for five edges freezes the first timer
        rd(ADR_CNT, cnt_m);
        @(posedge i_mclk) i_ce <= 1'b0;
        repeat (5) @(posedge i_mclk);
        i_ce <= 1'b1;
        rd(ADR_CNT, rv); chk(16'(rv - cnt_m) & 16'h00FF, 16'h0003);
        wr(ADR_CMPA1, 8'h10); wr(ADR_CMPB1, 8'h07); wr(ADR_CMPC1, 8'h05);
        rd(ADR_CMPB1, rv); chk(16'(rv), 16'h0007);
        // Random pulse widths either side of the eight-clock threshold
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            w = (r[0] ? 12 : 3) + (r[3:1] % 3);
            hl(w, 30, 16);
            chk(16'(pwm), 16'(w > 8));
            chk(16'(c3n - c3s), 16'h0005);
        end
        // Clamp three cut short by the next sync rise
        wr(ADR_CMPC1, 8'h30);
        hl(4, 20, 16);
        c3s = c3n;
        src.line(20, 0);
        chk(16'(clamp3), 16'h0000);
        chk(16'(c3n - c3s < 6), 16'h0001);
        repeat (30) @(posedge i_mclk);
        // Smallest legal compare A, sync longer than clamp one
        wr(ADR_CMPA1, 8'h02);
        hl(12, 20, 2);
        // Set on B, clear on A, capture on falling edge
        wr(ADR_CMPB2, 8'h01); wr(ADR_CMPA2, 8'h03); wr(ADR_OSEL, {4'h0, OS_SETB_CLRA});
        src.frame();
        cnt_m = 8'h00;
        tout_m = tout;
        capb = capn;
        repeat (8) tstep(OS_SETB_CLRA, 8'h03, 8'h01, 1'b0);
        // Toggle on A, capture on rising edge
        wr(ADR_CTRL, CTRL_RST | 8'h20); wr(ADR_OSEL, {4'h0, OS_TOGGLE_A}); wr(ADR_CMPA2, 8'h02);
        src.frame();
        cnt_m = 8'h00;
        // Capture B read in the line after each rising capture, 512 lines of 12 clocks apart
        for (int i = 1; i <= 520; i++) begin
            if (i == 3 || i == 515) begin
                fork
                    tstep(OS_TOGGLE_A, 8'h02, 8'h01, 1'b1);
                    rd(ADR_CAPB, rv);
                join
                if (i == 3) cb1 = rv;
            end else begin
                tstep(OS_TOGGLE_A, 8'h02, 8'h01, 1'b1);
            end
        end
        chk(16'(rv - cb1) & 16'h00FF, 16'((512 * 12 / FR_DIV8) >> 8));
        chk(16'(capn - capb), 16'(cap_m));
        end_sim();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
